/* File: hw/sync_coast_map.svh */
// Purpose: Named offsets, reset values and timing figures for the sync, coast and clamp control block.
// Assumes: Register byte address is four times the register index.
// Notes: Definitions only.
// Operation
// - Vsync override bit picks manual or automatic source.
// - Manual vsync select: 0 pin, 1 separator.
// - Clamp source bit: 0 internal, 1 pin.
// - Internal clamp timed from active hsync leading edge.
// - Clamp all three channels while clamp active.
// - Clamp pin polarity: 1 clamps on low.
// - Coast source: pin or selected vsync.
// - Coast polarity override: detected or software polarity.
// - Coast polarity bit; coast holds clock nominal.
// - Seek mode when allowed and syncs idle.
// - Power bit 0 powers down, 1 runs.
// - Slicer field inversely coded in 10 mV steps.
// - Slicer field resets to 23 (100 mV).
// - Per-channel clamp: 0 ground, 1 midscale.
// - Separator counts 5 MHz ticks to threshold.
// - Pre-coast starts coast lines before vsync.
// - Post-coast extends coast lines after vsync.
// - Hsync detect shows edges on hsync pin.
// - Active hsync status from detect bits.
// - Both hsyncs active: select bit decides.
// - Hsync override: status equals select bit.
// - Automatic: sog only 1, pin only 0.
// - Automatic vsync: pin if active, else separator.
// - Hsync select resets to 0, the pin.
`ifndef SYNC_COAST_MAP_SVH
`define SYNC_COAST_MAP_SVH
// ========================================
// Register indices
`define IDX_MODE   8'h0E
`define IDX_CLCO   8'h0F
`define IDX_SLICE  8'h10
`define IDX_SEPTH  8'h11
`define IDX_PRE    8'h12
`define IDX_POST   8'h13
`define IDX_STAT   8'h14
`define IDX_PWR    8'h18
// ========================================
// Reset values
`define RST_MODE   8'h40
`define RST_CLCO   8'h4C
`define RST_SLICE  8'hB8
`define RST_SEPTH  8'h20
`define RST_PRE    8'h00
`define RST_POST   8'h00
`define RST_PWR    8'h01
`define RST_POLCNT 8'h80
// ========================================
// Timing
`define MCLK_NS        10
`define SEP_TICK_NS    200
`define ACT_TIMEOUT_NS 100000
`endif

/* File: hw/sync_coast_pkg.sv */
// Purpose: Types for the sync, coast and clamp control block.
// Assumes: Field order follows the register bit order, bit 7 first.
// Notes: Offsets live in the map header.
package sync_coast_pkg;
   typedef struct packed {
      logic hs_pol_ovr; logic hs_pol; logic hs_out_pol; logic hs_ovr;
      logic hs_sel;     logic vs_out_inv; logic vs_ovr; logic vs_sel;
   } mode_type;
   typedef struct packed {
      logic clamp_ext; logic clamp_pol; logic coast_vs; logic cpol_ovr;
      logic cpol;      logic seek_allow; logic [1:0] spare;
   } clco_type;
   typedef struct packed {
      logic [4:0] slicer; logic [2:0] mid;
   } slice_type;
   typedef struct packed {
      logic hs_det; logic active_hsync_source; logic hs_pol_det; logic vs_det;
      logic active_vsync_source;    logic vs_pol_det; logic sog_det; logic coast_pol_det;
   } status_type;
   typedef struct packed {
      logic valid; logic write; logic [7:0] idx;
   } bus_req_type;
   typedef enum {CL_IDLE, CL_WAIT, CL_ON} clamp_state_type;
endpackage : sync_coast_pkg

/* File: hw/sync_coast_clamp_control.sv */
// Purpose: Sync source selection, coast and clamp generation with AHB-Lite registers.
// Assumes: One 100 MHz clock; all sync pins asynchronous.
// Notes: Zero wait states; unmapped addresses read zero and ignore writes.
//
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/1ns
`include "sync_coast_map.svh"
module sync_coast_clamp_control
   import sync_coast_pkg::*;
#(
   parameter int ACT_CYCLES  = `ACT_TIMEOUT_NS / `MCLK_NS,
   parameter int ACT_W       = 16,
   parameter int LINE_W      = 12,
   parameter int CLAMP_PLACE = 8,
   parameter int CLAMP_DUR   = 20
) (
   // Clock and reset
   input  wire logic        MCLK,
   input  wire logic        RST,
   // AHB-Lite slave
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   output logic      [31:0] HRDATA,
   output logic             HREADYOUT,
   output logic             HRESP,
   // Sync pins
   input  wire logic        HSYNC_IN,
   input  wire logic        VSYNC_IN,
   input  wire logic        SOG_IN,
   input  wire logic        COAST_IN,
   input  wire logic        CLAMP_IN,
   // Front end control
   output logic             CLAMP_ACT,
   output logic      [2:0]  CLAMP_MID,
   output logic             COAST_ACT,
   output logic             ACTIVE_HSYNC_SOURCE,
   output logic             ACTIVE_VSYNC_SOURCE,
   output logic             SEP_VSYNC,
   output logic             SEEK_MODE,
   output logic             POWER_DOWN,
   output logic      [4:0]  SLICER_LEVEL
);
   localparam int SEP_DIV = `SEP_TICK_NS / `MCLK_NS;
   localparam int HS = 0, VS = 1, SG = 2, CO = 3, CL = 4;

   // Checked while elaborating, so an unusable build stops before it runs.
   if (ACT_W < 2 || ACT_CYCLES < 2 || ACT_CYCLES >= (1 << ACT_W) || LINE_W < 8 || CLAMP_DUR < 1 ||
       CLAMP_PLACE < 0 || CLAMP_PLACE > 65535 || CLAMP_DUR > 65535) begin : g_bad_param
      $error("sync_coast_clamp_control: unsupported parameter value");
   end

   // ========================================
   // Pin synchronisers and activity detectors
   logic [4:0] s1_reg, s2_reg, s3_reg;
   logic [3:0] det_reg, det_next, pdet;
   logic [ACT_W-1:0] act_reg [4];
   logic [ACT_W-1:0] act_next [4];
   logic [7:0] pol_reg [4];
   logic [7:0] pol_next [4];

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         s1_reg <= 5'h00;
         s2_reg <= 5'h00;
         s3_reg <= 5'h00;
      end else begin
         s1_reg <= {CLAMP_IN, COAST_IN, SOG_IN, VSYNC_IN, HSYNC_IN};
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   for (genvar i = 0; i < 4; i++) begin : g_act
      // Mostly-low inputs carry positive pulses, so the counter leans toward high polarity.
      always_comb begin
         act_next[i] = act_reg[i];
         det_next[i] = det_reg[i];
         pol_next[i] = pol_reg[i];
         if (s2_reg[i] != s3_reg[i]) begin
            act_next[i] = '0;
            det_next[i] = 1'b1;
         end else if (act_reg[i] == ACT_W'(ACT_CYCLES - 1)) begin
            det_next[i] = 1'b0;
         end else begin
            act_next[i] = act_reg[i] + 1'b1;
         end
         if (!s2_reg[i] && pol_reg[i] != 8'hFF) pol_next[i] = pol_reg[i] + 8'h01;
         else if (s2_reg[i] && pol_reg[i] != 8'h00) pol_next[i] = pol_reg[i] - 8'h01;
      end
      always_ff @(posedge MCLK or posedge RST) begin
         if (RST) begin
            act_reg[i] <= '0;
            det_reg[i] <= 1'b0;
            pol_reg[i] <= `RST_POLCNT;
         end else begin
            act_reg[i] <= act_next[i];
            det_reg[i] <= det_next[i];
            pol_reg[i] <= pol_next[i];
         end
      end
      assign pdet[i] = pol_reg[i][7];
   end

   // ========================================
   // Register file over AHB-Lite
   bus_req_type req_reg, req_next;
   mode_type    mode_reg, mode_next;
   clco_type    cc_reg, cc_next;
   slice_type   sl_reg, sl_next;
   logic [7:0]  septh_reg, septh_next, pre_reg, pre_next, post_reg, post_next;
   logic        run_reg, run_next;
   logic [31:0] rd_reg, rd_next;
   status_type  stat;
   logic [7:0]  aidx, rv;
   logic        take;
   logic        ahs_reg, ahs_next, avs_reg, avs_next;

   always_comb begin
      stat = '{hs_det: det_reg[HS], active_hsync_source: ahs_reg, hs_pol_det: pdet[HS], vs_det: det_reg[VS], active_vsync_source: avs_reg,
               vs_pol_det: pdet[VS], sog_det: det_reg[SG], coast_pol_det: pdet[CO]};
      take = HSEL && HREADY && HTRANS[1];
      aidx = (HADDR[31:10] == 22'h000000) ? HADDR[9:2] : 8'hFF;
      req_next = '{valid: take, write: HWRITE, idx: aidx};
      mode_next = mode_reg;
      cc_next = cc_reg;
      sl_next = sl_reg;
      septh_next = septh_reg;
      pre_next = pre_reg;
      post_next = post_reg;
      run_next = run_reg;
      if (req_reg.valid && req_reg.write) begin
         unique case (req_reg.idx)
            `IDX_MODE:  mode_next = mode_type'(HWDATA[7:0]);
            `IDX_CLCO:  cc_next = clco_type'(HWDATA[7:0]);
            `IDX_SLICE: sl_next = slice_type'(HWDATA[7:0]);
            `IDX_SEPTH: septh_next = HWDATA[7:0];
            `IDX_PRE:   pre_next = HWDATA[7:0];
            `IDX_POST:  post_next = HWDATA[7:0];
            `IDX_PWR:   run_next = HWDATA[0];
            default:    run_next = run_reg;
         endcase
      end
      unique case (aidx)
         `IDX_MODE:  rv = mode_next;
         `IDX_CLCO:  rv = cc_next;
         `IDX_SLICE: rv = sl_next;
         `IDX_SEPTH: rv = septh_next;
         `IDX_PRE:   rv = pre_next;
         `IDX_POST:  rv = post_next;
         `IDX_STAT:  rv = stat;
         `IDX_PWR:   rv = {7'h00, run_next};
         default:    rv = 8'h00;
      endcase
      rd_next = (take && !HWRITE) ? {24'h000000, rv} : rd_reg;
   end

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         req_reg <= '0;
         mode_reg <= mode_type'(`RST_MODE);
         cc_reg <= clco_type'(`RST_CLCO);
         sl_reg <= slice_type'(`RST_SLICE);
         septh_reg <= `RST_SEPTH;
         pre_reg <= `RST_PRE;
         post_reg <= `RST_POST;
         run_reg <= 1'(`RST_PWR);
         rd_reg <= 32'h00000000;
      end else begin
         req_reg <= req_next;
         mode_reg <= mode_next;
         cc_reg <= cc_next;
         sl_reg <= sl_next;
         septh_reg <= septh_next;
         pre_reg <= pre_next;
         post_reg <= post_next;
         run_reg <= run_next;
         rd_reg <= rd_next;
      end
   end

   // ========================================
   // Source selection and sync separator
   logic       hs_pol, hs_lvl, hs_lead, sep_reg, sep_next, tick;
   logic [4:0] div_reg, div_next;
   logic [7:0] scnt_reg, scnt_next;
   logic       vs_act;

   always_comb begin
      if (mode_reg.hs_ovr || det_reg[HS] == det_reg[SG]) ahs_next = mode_reg.hs_sel;
      else ahs_next = det_reg[SG];
      avs_next = mode_reg.vs_ovr ? mode_reg.vs_sel : !det_reg[VS];
      hs_pol = mode_reg.hs_pol_ovr ? mode_reg.hs_pol : pdet[HS];
      hs_lvl = (ahs_reg ? s2_reg[SG] : s2_reg[HS]) ~^ hs_pol;
      hs_lead = hs_lvl && !((ahs_reg ? s3_reg[SG] : s3_reg[HS]) ~^ hs_pol);
      vs_act = avs_reg ? sep_reg : (s2_reg[VS] ~^ pdet[VS]);
      tick = (div_reg == 5'(SEP_DIV - 1));
      div_next = tick ? 5'h00 : div_reg + 5'h01;
      sep_next = sep_reg;
      scnt_next = scnt_reg;
      // A long pulse outlasts the threshold; short hsync pulses never reach it.
      if (hs_lvl == sep_reg) scnt_next = 8'h00;
      else if (tick && scnt_reg >= septh_reg) begin
         sep_next = hs_lvl;
         scnt_next = 8'h00;
      end else if (tick && scnt_reg != 8'hFF) scnt_next = scnt_reg + 8'h01;
   end

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         ahs_reg <= 1'b0;
         avs_reg <= 1'b0;
         div_reg <= 5'h00;
         sep_reg <= 1'b0;
         scnt_reg <= 8'h00;
      end else begin
         ahs_reg <= ahs_next;
         avs_reg <= avs_next;
         div_reg <= div_next;
         sep_reg <= sep_next;
         scnt_reg <= scnt_next;
      end
   end

   // ========================================
   // Coast with pre and post windows
   logic              cbase, cbase_reg, cpol, pre_win, coast_next;
   logic [LINE_W-1:0] line_reg, line_next, frame_reg, frame_next;
   logic [7:0]        pcnt_reg, pcnt_next;

   always_comb begin
      cpol = cc_reg.cpol_ovr ? cc_reg.cpol : pdet[CO];
      cbase = cc_reg.coast_vs ? vs_act : (s2_reg[CO] == cpol);
      line_next = line_reg;
      frame_next = frame_reg;
      pcnt_next = pcnt_reg;
      if (cbase && !cbase_reg) begin
         frame_next = line_reg;
         line_next = '0;
      end else if (hs_lead && line_reg != '1) line_next = line_reg + 1'b1;
      if (cbase_reg && !cbase) pcnt_next = post_reg;
      else if (hs_lead && pcnt_reg != 8'h00) pcnt_next = pcnt_reg - 8'h01;
      // Pre-coast leans on the previous frame's line count, so the first frame gets no early window.
      pre_win = pre_reg != 8'h00 && frame_reg != '0 && (line_reg + LINE_W'(pre_reg)) >= frame_reg;
      coast_next = cbase || pre_win || pcnt_reg != 8'h00;
   end

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         cbase_reg <= 1'b0;
         line_reg <= '0;
         frame_reg <= '0;
         pcnt_reg <= 8'h00;
      end else begin
         cbase_reg <= cbase;
         line_reg <= line_next;
         frame_reg <= frame_next;
         pcnt_reg <= pcnt_next;
      end
   end

   // ========================================
   // Clamp timing
   clamp_state_type cst_reg, cst_next;
   logic [15:0]     ccnt_reg, ccnt_next;
   logic            clamp_next;

   always_comb begin
      cst_next = cst_reg;
      ccnt_next = ccnt_reg + 16'h0001;
      if (hs_lead) begin
         cst_next = (CLAMP_PLACE == 0) ? CL_ON : CL_WAIT;
         ccnt_next = 16'h0001;
      end else begin
         unique case (cst_reg)
            CL_IDLE: ccnt_next = 16'h0000;
            CL_WAIT: if (ccnt_reg >= 16'(CLAMP_PLACE)) begin
               cst_next = CL_ON;
               ccnt_next = 16'h0001;
            end
            CL_ON: if (ccnt_reg >= 16'(CLAMP_DUR)) begin
               cst_next = CL_IDLE;
               ccnt_next = 16'h0000;
            end
         endcase
      end
      clamp_next = cc_reg.clamp_ext ? (s2_reg[CL] ^ cc_reg.clamp_pol) : (cst_reg == CL_ON);
   end

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         cst_reg <= CL_IDLE;
         ccnt_reg <= 16'h0000;
      end else begin
         cst_reg <= cst_next;
         ccnt_reg <= ccnt_next;
      end
   end

   // ========================================
   // Output flops
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         CLAMP_ACT <= 1'b0;
         CLAMP_MID <= 3'h0;
         COAST_ACT <= 1'b0;
         ACTIVE_HSYNC_SOURCE <= 1'b0;
         ACTIVE_VSYNC_SOURCE <= 1'b0;
         SEP_VSYNC <= 1'b0;
         SEEK_MODE <= 1'b0;
         POWER_DOWN <= 1'b0;
         SLICER_LEVEL <= 5'h00;
         HREADYOUT <= 1'b1;
         HRESP <= 1'b0;
      end else begin
         CLAMP_ACT <= clamp_next;
         CLAMP_MID <= sl_next.mid;
         COAST_ACT <= coast_next;
         ACTIVE_HSYNC_SOURCE <= ahs_next;
         ACTIVE_VSYNC_SOURCE <= avs_next;
         SEP_VSYNC <= sep_next;
         SEEK_MODE <= cc_reg.seek_allow && !(det_reg[HS] || det_reg[VS] || det_reg[SG]);
         POWER_DOWN <= !run_next;
         SLICER_LEVEL <= sl_next.slicer;
         HREADYOUT <= 1'b1;
         HRESP <= 1'b0;
      end
   end
   assign HRDATA = rd_reg;

   // ========================================
   // Checks
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RST);

   property p_ahs_ovr;
      mode_reg.hs_ovr |=> ACTIVE_HSYNC_SOURCE == $past(mode_reg.hs_sel);
   endproperty
   a_ahs_ovr: assert property (p_ahs_ovr) else $error("active hsync ignores override");
   property p_ahs_sog;
      (!mode_reg.hs_ovr && !det_reg[HS] && det_reg[SG]) |=> ACTIVE_HSYNC_SOURCE;
   endproperty
   a_ahs_sog: assert property (p_ahs_sog) else $error("sog-only not selected");
   property p_avs_auto;
      !mode_reg.vs_ovr |-> ##1 avs_reg == !$past(det_reg[VS]);
   endproperty
   a_avs_auto: assert property (p_avs_auto) else $error("vsync auto selection wrong");
   property p_clamp_ext;
      cc_reg.clamp_ext |=> CLAMP_ACT == ($past(s2_reg[CL]) ^ $past(cc_reg.clamp_pol));
   endproperty
   a_clamp_ext: assert property (p_clamp_ext) else $error("external clamp polarity wrong");
   property p_coast_pin;
      (!cc_reg.coast_vs && cc_reg.cpol_ovr && pre_reg == 8'h00 && pcnt_reg == 8'h00)
         |=> COAST_ACT == ($past(s2_reg[CO]) == $past(cc_reg.cpol));
   endproperty
   a_coast_pin: assert property (p_coast_pin) else $error("coast pin polarity wrong");
   property p_post;
      (cbase_reg && !cbase) |=> pcnt_reg == $past(post_reg);
   endproperty
   a_post: assert property (p_post) else $error("post-coast not loaded");
   property p_sep;
      $changed(sep_reg) |-> $past(tick) && $past(scnt_reg) >= $past(septh_reg);
   endproperty
   a_sep: assert property (p_sep) else $error("separator toggled early");
   property p_seek;
      (det_reg[HS] || det_reg[VS] || det_reg[SG]) |=> !SEEK_MODE;
   endproperty
   a_seek: assert property (p_seek) else $error("seek while sync active");
   property p_lead_clamp;
      (hs_lead && !cc_reg.clamp_ext && CLAMP_PLACE > 0) |=> !clamp_next;
   endproperty
   a_lead_clamp: assert property (p_lead_clamp) else $error("clamp not restarted");
endmodule : sync_coast_clamp_control

/* File: testbench/sync_source_model.sv */
// Purpose: Video source that drives the sync, coast and clamp pins of the block.
// Assumes: Pins are asynchronous to the block clock; periods are chosen unrelated to it.
// Notes: A disabled sync line idles low, which is a legal steady level.
`timescale 1ns/1ns
module sync_source_model (
   // Enables from the bench
   input  wire logic hs_en,
   input  wire logic sog_en,
   input  wire logic vs_en,
   input  wire logic coast_lvl,
   input  wire logic clamp_lvl,
   // Pins towards the block
   output logic      hsync_pin,
   output logic      sog_pin,
   output logic      vsync_pin,
   output logic      coast_pin,
   output logic      clamp_pin
);
   // ========================================
   // Pulse trains
   // Periods stay well inside the shortened activity timeout so detection holds.
   initial begin
      hsync_pin = 1'b0;
      sog_pin   = 1'b0;
      vsync_pin = 1'b0;
   end
   always begin
      #303;
      if (hs_en) begin
         hsync_pin = 1'b1;
         #41;
         hsync_pin = 1'b0;
      end
   end
   always begin
      #317;
      if (sog_en) begin
         sog_pin = 1'b1;
         #37;
         sog_pin = 1'b0;
      end
   end
   always begin
      #487;
      if (vs_en) begin
         vsync_pin = 1'b1;
         #97;
         vsync_pin = 1'b0;
      end
   end
   assign coast_pin = coast_lvl;
   assign clamp_pin = clamp_lvl;
endmodule : sync_source_model

/* File: testbench/sync_coast_clamp_control_test.sv */
// Purpose: Self-checking bench for the sync, coast and clamp control block.
// Assumes: Zero wait state slave; activity timeout shortened to 64 clocks.
// Notes: Each scenario after t_reset configures over the bus and judges the outputs itself.
`timescale 1ns/1ns
`include "sync_coast_map.svh"
module sync_coast_clamp_control_test;
   import sync_coast_pkg::*;
   logic        mclk, rst, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans;
   logic [2:0]  clamp_mid;
   logic [4:0]  slicer_level;
   logic        clamp_act, coast_act, active_hsync_source, active_vsync_source, sep_vsync, seek_mode, power_down;
   logic        hs_en, sog_en, vs_en, coast_lvl, clamp_lvl;
   logic        hs_p, sog_p, vs_p, coast_p, clamp_p;
   logic [31:0] rd;
   int          miscompares, n_checks, cycles;
   // ========================================
   // Clock, partner and design
   initial mclk = 1'b0;
   always #5 mclk = ~mclk;
   sync_source_model src (.hs_en(hs_en), .sog_en(sog_en), .vs_en(vs_en), .coast_lvl(coast_lvl),
      .clamp_lvl(clamp_lvl), .hsync_pin(hs_p), .sog_pin(sog_p), .vsync_pin(vs_p), .coast_pin(coast_p),
      .clamp_pin(clamp_p));
   sync_coast_clamp_control #(.ACT_CYCLES(64)) uut (.MCLK(mclk), .RST(rst), .HSEL(hsel), .HADDR(haddr),
      .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
      .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .HSYNC_IN(hs_p), .VSYNC_IN(vs_p),
      .SOG_IN(sog_p), .COAST_IN(coast_p), .CLAMP_IN(clamp_p), .CLAMP_ACT(clamp_act),
      .CLAMP_MID(clamp_mid), .COAST_ACT(coast_act), .ACTIVE_HSYNC_SOURCE(active_hsync_source),
      .ACTIVE_VSYNC_SOURCE(active_vsync_source), .SEP_VSYNC(sep_vsync), .SEEK_MODE(seek_mode),
      .POWER_DOWN(power_down), .SLICER_LEVEL(slicer_level));
   // ========================================
   // Shared tasks
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic wait_ready();
      @(posedge mclk);
      while (hreadyout !== 1'b1) @(posedge mclk);
   endtask : wait_ready
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      @(posedge mclk);
      hsel <= 1'b1; haddr <= {22'h0, idx, 2'b00}; htrans <= 2'b10; hwrite <= 1'b1;
      wait_ready();
      htrans <= 2'b00; hwdata <= {24'h0, d};
      wait_ready();
      hsel <= 1'b0;
      repeat (3) @(posedge mclk);
   endtask : wr
   task automatic rdreg(input logic [7:0] idx, output logic [31:0] d);
      @(posedge mclk);
      hsel <= 1'b1; haddr <= {22'h0, idx, 2'b00}; htrans <= 2'b10; hwrite <= 1'b0;
      wait_ready();
      htrans <= 2'b00;
      wait_ready();
      d = hrdata;
      hsel <= 1'b0;
   endtask : rdreg
   task automatic finish_test();
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : finish_test
   // ========================================
   // Scenarios
   task automatic t_reset();
      rdreg(`IDX_MODE, rd);  check("mode", rd, {24'h0, `RST_MODE});
      rdreg(`IDX_CLCO, rd);  check("clco", rd, {24'h0, `RST_CLCO});
      rdreg(`IDX_SLICE, rd); check("slice", rd, {24'h0, 5'h17, 3'h0});
      rdreg(`IDX_SEPTH, rd); check("septh", rd, 32'h20);
      rdreg(`IDX_PRE, rd);   check("pre", rd, 32'h0);
      rdreg(`IDX_POST, rd);  check("post", rd, 32'h0);
      rdreg(8'h3F, rd);      check("unmapped", rd, 32'h0);
      check("ready resp", {30'h0, hreadyout, hresp}, 32'h2);
      check("slicer out", {27'h0, slicer_level}, 32'h17);
      check("power", {31'h0, power_down}, 32'h0);
   endtask : t_reset
   task automatic t_chan_clamp();
      wr(`IDX_SLICE, 8'h05);
      check("mid", {29'h0, clamp_mid}, 32'h5);
      check("slicer", {27'h0, slicer_level}, 32'h0);
      wr(`IDX_SLICE, 8'hFA);
      check("mid2", {29'h0, clamp_mid}, 32'h2);
      check("slicer2", {27'h0, slicer_level}, 32'h1F);
   endtask : t_chan_clamp
   task automatic t_hsync();
      int n;
      hs_en = 1'b1; sog_en = 1'b0;
      n = 0;
      while (clamp_act !== 1'b1 && n < 100) begin
         @(posedge mclk);
         n++;
      end
      n = 0;
      while (clamp_act === 1'b1 && n < 100) begin
         @(posedge mclk);
         n++;
      end
      check("clamp dur", n, 32'd20);
      repeat (150) @(posedge mclk);
      rdreg(`IDX_STAT, rd);
      check("hs det", rd[7] & ~rd[1], 1'b1);
      check("ahs pin", {31'h0, rd[6]}, 32'h0);
      // Two hsync periods of post-coast outlast the ten cycles sampled here.
      wr(`IDX_POST, 8'h02);
      wr(`IDX_CLCO, 8'h5C);
      coast_lvl <= 1'b1;
      repeat (8) @(posedge mclk);
      coast_lvl <= 1'b0;
      repeat (10) @(posedge mclk);
      check("post hold", {31'h0, coast_act}, 32'h1);
      repeat (120) @(posedge mclk);
      check("post end", {31'h0, coast_act}, 32'h0);
      wr(`IDX_CLCO, `RST_CLCO);
      wr(`IDX_POST, 8'h00);
      hs_en = 1'b0; sog_en = 1'b1;
      repeat (200) @(posedge mclk);
      rdreg(`IDX_STAT, rd);
      check("hs idle", {30'h0, rd[7], rd[1]}, 32'h1);
      check("ahs sog", {31'h0, active_hsync_source}, 32'h1);
      hs_en = 1'b1;
      wr(`IDX_MODE, 8'h48);
      repeat (150) @(posedge mclk);
      check("ahs both", {31'h0, active_hsync_source}, 32'h1);
      hs_en = 1'b0;
      wr(`IDX_MODE, 8'h50);
      repeat (150) @(posedge mclk);
      check("ahs ovr", {31'h0, active_hsync_source}, 32'h0);
      sog_en = 1'b0;
      wr(`IDX_MODE, `RST_MODE);
   endtask : t_hsync
   task automatic t_vsync();
      vs_en = 1'b0;
      repeat (200) @(posedge mclk);
      check("avs sep", {31'h0, active_vsync_source}, 32'h1);
      vs_en = 1'b1;
      repeat (150) @(posedge mclk);
      check("avs pin", {31'h0, active_vsync_source}, 32'h0);
      wr(`IDX_MODE, 8'h41);
      check("avs auto", {31'h0, active_vsync_source}, 32'h0);
      wr(`IDX_MODE, 8'h43);
      check("avs ovr1", {31'h0, active_vsync_source}, 32'h1);
      vs_en = 1'b0;
      wr(`IDX_MODE, 8'h42);
      repeat (200) @(posedge mclk);
      check("avs ovr0", {31'h0, active_vsync_source}, 32'h0);
      wr(`IDX_MODE, `RST_MODE);
   endtask : t_vsync
   task automatic t_sep();
      // Two ticks still outlast the short hsync pulses of the source.
      wr(`IDX_SEPTH, 8'h02);
      wr(`IDX_MODE, 8'h80);
      repeat (10) @(posedge mclk);
      check("sep early", {31'h0, sep_vsync}, 32'h0);
      repeat (60) @(posedge mclk);
      check("sep set", {31'h0, sep_vsync}, 32'h1);
      wr(`IDX_MODE, `RST_MODE);
      wr(`IDX_SEPTH, `RST_SEPTH);
   endtask : t_sep
   task automatic t_ext_clamp();
      wr(`IDX_CLCO, 8'hCC);
      clamp_lvl <= 1'b0; repeat (8) @(posedge mclk);
      check("clamp low", {31'h0, clamp_act}, 32'h1);
      clamp_lvl <= 1'b1; repeat (8) @(posedge mclk);
      check("pass high", {31'h0, clamp_act}, 32'h0);
      wr(`IDX_CLCO, 8'h8C);
      repeat (8) @(posedge mclk);
      check("clamp high", {31'h0, clamp_act}, 32'h1);
      wr(`IDX_CLCO, `RST_CLCO);
   endtask : t_ext_clamp
   task automatic t_coast();
      // Software sets the override so the written polarity is the one used.
      wr(`IDX_CLCO, 8'h5C);
      coast_lvl <= 1'b1; repeat (8) @(posedge mclk);
      check("coast hi", {31'h0, coast_act}, 32'h1);
      coast_lvl <= 1'b0; repeat (8) @(posedge mclk);
      check("coast off", {31'h0, coast_act}, 32'h0);
      wr(`IDX_CLCO, 8'h54);
      repeat (8) @(posedge mclk);
      check("coast lo", {31'h0, coast_act}, 32'h1);
      wr(`IDX_CLCO, `RST_CLCO);
   endtask : t_coast
   task automatic t_power_seek();
      wr(`IDX_PWR, 8'h00);
      check("pd on", {31'h0, power_down}, 32'h1);
      wr(`IDX_PWR, 8'h01);
      check("pd off", {31'h0, power_down}, 32'h0);
      repeat (200) @(posedge mclk);
      check("seek", {31'h0, seek_mode}, 32'h1);
      wr(`IDX_CLCO, 8'h48);
      check("no seek", {31'h0, seek_mode}, 32'h0);
      wr(`IDX_CLCO, `RST_CLCO);
   endtask : t_power_seek
   // ========================================
   // Sequence and timeout
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         finish_test();
      end
   end
   initial begin
      miscompares = 0; n_checks = 0; cycles = 0;
      rst = 1'b1; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00; hwrite = 1'b0; hwdata = 32'h0;
      hs_en = 1'b0; sog_en = 1'b0; vs_en = 1'b0; coast_lvl = 1'b0; clamp_lvl = 1'b1;
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      t_reset();
      t_chan_clamp();
      t_ext_clamp();
      t_coast();
      t_power_seek();
      t_hsync();
      t_vsync();
      t_sep();
      finish_test();
   end
endmodule : sync_coast_clamp_control_test
